// *** core/tps_touch_ctrl.sv ***
// Touch power-state control: APB registers, power state, scan sequencer,
// touch compare, pattern detect and interrupt.
// Assumes an analog front end that answers each meas_start with meas_done.
// Assumes reset is asynchronous and active high; one clock domain.
//
// Behaviour
// [R1] Four power states picked from three control bits.
// [R2] A state change clears touches and status of deactivated channels.
// [R3] No bits set: Active state, scan Active-enabled inputs only.
// [R4] Standby bit: scan Standby inputs, interrupts and bus still work.
// [R5] Combined bit: scan Active and Standby inputs, interrupts still work.
// [R6] Deep sleep bit: lowest power, no input scanned.
// [R7] Bus traffic wakes device in deep sleep without clearing the bit.
// [R8] Host leaves deep sleep by writing the deep sleep bit to zero.
// [R9] Active uses Active settings and a threshold per channel.
// [R10] Standby uses Standby settings and one shared threshold.
// [R11] Combo: Active inputs use Active settings; overlap takes Active.
// [R12] Combo takes cycle period from standby_cycle_period.
// [R13] Combo gain: active_amplification or combined_standby_amplification per input.
// [R14] Host may poll status or enable the touch interrupt.
// [R15] Selected button set touched together sets pattern bit and interrupt.
// [R16] Eight inputs, each enabled and judged with its own settings.
// [R17] Outside deep sleep, cycles repeat, polling inputs first to eighth.
// [R18] Any newly enabled input is calibrated, including by state change.
// [R19] Deep sleep beats combo, combo beats standby.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/100ps
module tps_touch_ctrl #(
  parameter int NUM_CH = 8,
  parameter int CYCLE_UNIT_CYC = tps_pkg::CYCLE_UNIT_US * tps_pkg::CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_wake,
  output logic core_awake,
  output tps_pkg::tps_pstate_t power_state,
  output logic meas_start,
  output tps_pkg::tps_meas_t meas_req,
  input wire logic meas_done,
  input wire logic [7:0] meas_delta,
  output logic irq
);

  // ==========================================================
  // Registers
  logic [2:0] ctrl_q;
  logic [NUM_CH-1:0] act_en_q;
  logic [NUM_CH-1:0] stb_en_q;
  tps_pkg::tps_cfg_t act_cfg_q;
  tps_pkg::tps_cfg_t stb_cfg_q;
  logic [7:0] stb_thr_q;
  logic [NUM_CH-1:0] pattern_q;
  // Status and mask carry one bit per channel plus the pattern bit
  logic [NUM_CH:0] int_mask_q;
  logic [NUM_CH:0] int_status_q;
  logic [NUM_CH:0] int_status_d;
  logic [7:0] thr_q [NUM_CH];
  logic [NUM_CH-1:0] touch_q;
  logic [NUM_CH-1:0] touch_d;
  logic [NUM_CH-1:0] prev_en_q;
  logic [NUM_CH-1:0] cal_pend_q;
  logic [NUM_CH-1:0] cal_pend_d;
  logic pat_hit_q;
  logic [31:0] prdata_q;
  logic slverr_q;
  tps_pkg::tps_seq_t seq_q;
  tps_pkg::tps_seq_t seq_d;
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic [23:0] timer_q;
  logic [23:0] timer_d;
  logic meas_start_q;
  tps_pkg::tps_meas_t meas_req_q;
  tps_pkg::tps_meas_t req_d;

  // ==========================================================
  // Bus decode
  // Writes land in the access cycle; pready is high in that same cycle
  // Threshold block decodes eight words from its base address
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire sel_ctrl = paddr == tps_pkg::ADDR_CTRL;
  wire sel_ists = paddr == tps_pkg::ADDR_INT_STATUS;
  wire sel_imask = paddr == tps_pkg::ADDR_INT_MASK;
  wire sel_act_en = paddr == tps_pkg::ADDR_ACT_EN;
  wire sel_stb_en = paddr == tps_pkg::ADDR_STB_EN;
  wire sel_act_cfg = paddr == tps_pkg::ADDR_ACT_CFG;
  wire sel_stb_cfg = paddr == tps_pkg::ADDR_STB_CFG;
  wire sel_stb_thr = paddr == tps_pkg::ADDR_STB_THR;
  wire sel_pattern = paddr == tps_pkg::ADDR_PATTERN;
  wire sel_thr = paddr[11:5] == tps_pkg::ADDR_THR_BASE[11:5] && paddr[1:0] == 2'b00;
  wire [2:0] thr_idx = paddr[4:2];
  wire [NUM_CH:0] w1c = (wr_en && sel_ists) ? pwdata[NUM_CH:0] : '0;

  // ==========================================================
  // ==========================================================
  // Power state from control bits, deep before combo before standby
  // Priority chain so that any mix of bits still names one state
  tps_pkg::tps_pstate_t pstate;
  assign pstate = ctrl_q[tps_pkg::CTRL_DEEP] ? tps_pkg::PS_DEEP :          // see [R19] [R6]
                  ctrl_q[tps_pkg::CTRL_COMBINED] ? tps_pkg::PS_COMBO :     // see [R5]
                  ctrl_q[tps_pkg::CTRL_STANDBY] ? tps_pkg::PS_STANDBY :    // see [R4]
                  tps_pkg::PS_ACTIVE;                                      // see [R1] [R3]

  // Inputs scanned in the present state
  // Deactivated and new sets come from last cycle's scan set,
  // so a state change and an enable write are handled alike
  wire [NUM_CH-1:0] scan_en =
    (pstate == tps_pkg::PS_ACTIVE) ? act_en_q :                            // see [R3]
    (pstate == tps_pkg::PS_STANDBY) ? stb_en_q :                           // see [R4]
    (pstate == tps_pkg::PS_COMBO) ? (act_en_q | stb_en_q) : '0;            // see [R5] [R6]
  wire [NUM_CH-1:0] deact = prev_en_q & ~scan_en;                          // see [R2]
  wire [NUM_CH-1:0] newly = scan_en & ~prev_en_q;                          // see [R18]

  // Deep sleep wake on addressed bus traffic, bit itself untouched
  // Wake is a level: the core sleeps again as soon as traffic stops
  assign core_awake = (pstate != tps_pkg::PS_DEEP) | bus_wake;             // see [R7]
  assign power_state = pstate;

  // ==========================================================
  // Cycle period code: combo uses the standby field
  // Product is sized to the timer; the largest code still fits 24 bits
  wire [1:0] cyc_code = (pstate == tps_pkg::PS_ACTIVE) ? act_cfg_q.cycle :
                        stb_cfg_q.cycle;                                   // see [R12] [R10]
  wire [23:0] period = 24'((24'(cyc_code) + 24'h1) * 24'(CYCLE_UNIT_CYC));

  // ==========================================================
  // Next enabled input at or after the scan index
  // Returns NUM_CH when no enabled input is left in this cycle
  function automatic logic [3:0] first_from(input logic [NUM_CH-1:0] m, input logic [3:0] s);
    logic [3:0] r;
    r = 4'(NUM_CH);
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (m[i] && 4'(i) >= s) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  wire [3:0] next_ch = first_from(scan_en, idx_q);                         // see [R17]
  wire [2:0] nch = next_ch[2:0];
  wire use_act = (pstate == tps_pkg::PS_ACTIVE) ||
                 (pstate == tps_pkg::PS_COMBO && act_en_q[nch]);           // see [R11]
  tps_pkg::tps_cfg_t sel_cfg;
  assign sel_cfg = use_act ? act_cfg_q : stb_cfg_q;                        // see [R9] [R10] [R13]

  // ==========================================================
  // Threshold of the channel under measurement
  // Taken from the request register, so a state change mid-wait
  // judges the result with the settings of the new state
  wire [2:0] mch = meas_req_q.chan;
  wire m_act = (pstate == tps_pkg::PS_ACTIVE) ||
               (pstate == tps_pkg::PS_COMBO && act_en_q[mch]);
  wire [7:0] thr_sel = m_act ? thr_q[mch] : stb_thr_q;                     // see [R9] [R10]
  wire meas_ok = (seq_q == tps_pkg::SQ_WAIT) && meas_done && scan_en[mch];
  wire is_touch = meas_delta >= thr_sel;                                   // see [R16]

  // Pattern of buttons touched together
  // An empty pattern never matches, so the feature is off after reset
  wire pat_hit = (pattern_q != '0) && ((touch_q & pattern_q) == pattern_q); // see [R15]

  // ==========================================================
  // Scan sequencer
  // IDLE waits out the period, SCAN picks the next input, WAIT holds
  always_comb begin
    seq_d = seq_q;
    idx_d = idx_q;
    req_d = meas_req_q;
    timer_d = (timer_q == '1) ? timer_q : timer_q + 24'h1;
    unique case (seq_q)
      tps_pkg::SQ_IDLE: begin
        // Start a cycle once the period ran out, or at once if overrun
        if (pstate != tps_pkg::PS_DEEP && timer_q >= period) begin         // see [R17] [R6]
          seq_d = tps_pkg::SQ_SCAN;
          idx_d = 4'h0;
          timer_d = 24'h0;
        end
      end
      tps_pkg::SQ_SCAN: begin
        if (pstate == tps_pkg::PS_DEEP || next_ch >= 4'(NUM_CH)) begin     // see [R6]
          seq_d = tps_pkg::SQ_IDLE;
        end else begin
          seq_d = tps_pkg::SQ_WAIT;
          req_d.chan = nch;
          req_d.cal = cal_pend_q[nch] | newly[nch];                        // see [R18]
          req_d.sens = sel_cfg.sens;
          req_d.avg = sel_cfg.avg;
          req_d.sample = sel_cfg.sample;
          req_d.gain = sel_cfg.gain;                                       // see [R13]
        end
      end
      tps_pkg::SQ_WAIT: begin
        if (meas_done) begin
          seq_d = tps_pkg::SQ_SCAN;
          idx_d = {1'b0, meas_req_q.chan} + 4'h1;                          // see [R17]
        end
      end
      default: begin
        seq_d = tps_pkg::SQ_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Touch and calibration bookkeeping
  // A result for a channel no longer scanned is dropped
  // A calibration result clears touch and the pending flag
  always_comb begin
    touch_d = touch_q & ~deact;                                            // see [R2]
    cal_pend_d = (cal_pend_q | newly) & scan_en;                           // see [R18]
    if (meas_ok) begin
      touch_d[mch] = ~meas_req_q.cal & is_touch;
      if (meas_req_q.cal) begin
        cal_pend_d[mch] = newly[mch];
      end
    end
  end

  // ==========================================================
  // Sticky status: hardware set wins over write-one clear
  // Pattern bit is kept until software clears it; state changes spare it
  wire [NUM_CH:0] ev_set = {pat_hit & ~pat_hit_q, touch_d & ~touch_q};     // see [R15] [R14]
  assign int_status_d = (int_status_q & ~w1c & {1'b1, ~deact}) | ev_set;   // see [R2]

  // ==========================================================
  // Bus answer: read data latched in setup, ready in first access cycle
  // Unmapped addresses read zero and flag pslverr
  logic [31:0] rd_mux;
  logic rd_err;
  always_comb begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    if (sel_ctrl) begin
      rd_mux = {29'h0, ctrl_q};
    end else if (paddr == tps_pkg::ADDR_STATE) begin
      rd_mux = {29'h0, core_awake, pstate};
    end else if (paddr == tps_pkg::ADDR_TOUCH) begin
      rd_mux = 32'(touch_q);                                               // see [R14]
    end else if (sel_ists) begin
      rd_mux = 32'(int_status_q);
    end else if (sel_imask) begin
      rd_mux = 32'(int_mask_q);
    end else if (sel_act_en) begin
      rd_mux = 32'(act_en_q);
    end else if (sel_stb_en) begin
      rd_mux = 32'(stb_en_q);
    end else if (sel_act_cfg) begin
      rd_mux = act_cfg_q;
    end else if (sel_stb_cfg) begin
      rd_mux = stb_cfg_q;
    end else if (sel_stb_thr) begin
      rd_mux = {24'h0, stb_thr_q};
    end else if (sel_pattern) begin
      rd_mux = 32'(pattern_q);
    end else if (paddr == tps_pkg::ADDR_CAL_PEND) begin
      rd_mux = 32'(cal_pend_q);
    end else if (sel_thr) begin
      rd_mux = {24'h0, thr_q[thr_idx]};
    end else begin
      rd_err = 1'b1;
    end
  end

  assign pready = psel & penable;
  assign pslverr = psel & penable & slverr_q;
  assign prdata = prdata_q;
  assign meas_start = meas_start_q;
  assign meas_req = meas_req_q;
  assign irq = |(int_status_q & int_mask_q);                               // see [R14] [R15]

  // Answer registers
  // Captured in setup so read data stands through the access phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0 : rd_mux;
      slverr_q <= rd_err;
    end
  end

  // ==========================================================
  // Software-written control, deep sleep left only by a host write
  // Reserved control bits are dropped; cfg words keep all 32 bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q <= 3'h0;
      int_mask_q <= '0;
      act_en_q <= tps_pkg::RST_ACT_EN;
      stb_en_q <= tps_pkg::RST_STB_EN;
      act_cfg_q <= tps_pkg::RST_CFG;
      stb_cfg_q <= tps_pkg::RST_CFG;
      stb_thr_q <= tps_pkg::RST_STB_THR;
      pattern_q <= '0;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_q <= pwdata[2:0];                                 // see [R8] [R1]
      if (sel_imask) int_mask_q <= pwdata[NUM_CH:0];                       // see [R14]
      if (sel_act_en) act_en_q <= pwdata[NUM_CH-1:0];
      if (sel_stb_en) stb_en_q <= pwdata[NUM_CH-1:0];
      if (sel_act_cfg) act_cfg_q <= pwdata;
      if (sel_stb_cfg) stb_cfg_q <= pwdata;
      if (sel_stb_thr) stb_thr_q <= pwdata[7:0];
      if (sel_pattern) pattern_q <= pwdata[NUM_CH-1:0];
    end
  end

  // ==========================================================
  // Per-channel thresholds
  // One register per channel, picked by word index within the block
  for (genvar g = 0; g < NUM_CH; g++) begin : g_thr
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        thr_q[g] <= tps_pkg::RST_THR;
      end else if (wr_en && sel_thr && thr_idx == 3'(g)) begin
        thr_q[g] <= pwdata[7:0];                                           // see [R9]
      end
    end
  end

  // ==========================================================
  // Sequencer and measurement state
  // Timer starts saturated so the first cycle begins right after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      seq_q <= tps_pkg::SQ_IDLE;
      idx_q <= 4'h0;
      timer_q <= '1;
      meas_req_q <= '0;
      meas_start_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      idx_q <= idx_d;
      timer_q <= timer_d;
      meas_req_q <= req_d;
      meas_start_q <= (seq_q == tps_pkg::SQ_SCAN) && (seq_d == tps_pkg::SQ_WAIT);
    end
  end

  // ==========================================================
  // Touch, status and calibration state
  // prev_en_q starts empty, so every input enabled at reset calibrates
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      touch_q <= '0;
      int_status_q <= '0;
      prev_en_q <= '0;
      cal_pend_q <= '0;
      pat_hit_q <= 1'b0;
    end else begin
      touch_q <= touch_d;
      int_status_q <= int_status_d;
      prev_en_q <= scan_en;
      cal_pend_q <= cal_pend_d;
      pat_hit_q <= pat_hit;
    end
  end

endmodule

// *** core/tps_pkg.sv ***
// Package for the touch power-state control block: register map,
// field layouts, reset values, state encodings and shared types.
// Assumes a 32-bit APB master and an analog front end outside.
package tps_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATE = 12'h004;
  localparam logic [11:0] ADDR_TOUCH = 12'h008;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_INT_MASK = 12'h010;
  localparam logic [11:0] ADDR_ACT_EN = 12'h014;
  localparam logic [11:0] ADDR_STB_EN = 12'h018;
  localparam logic [11:0] ADDR_ACT_CFG = 12'h01C;
  localparam logic [11:0] ADDR_STB_CFG = 12'h020;
  localparam logic [11:0] ADDR_STB_THR = 12'h024;
  localparam logic [11:0] ADDR_PATTERN = 12'h028;
  localparam logic [11:0] ADDR_CAL_PEND = 12'h02C;
  localparam logic [11:0] ADDR_THR_BASE = 12'h040;

  // ==========================================================
  // Control bit positions and the pattern interrupt bit
  localparam int CTRL_STANDBY = 0;
  localparam int CTRL_COMBINED = 1;
  localparam int CTRL_DEEP = 2;
  localparam int INT_PATTERN = 8;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_ACT_EN = 8'hFF;
  localparam logic [7:0] RST_STB_EN = 8'h00;
  localparam logic [7:0] RST_THR = 8'h40;
  localparam logic [7:0] RST_STB_THR = 8'h40;
  localparam logic [31:0] RST_CFG = 32'h0000_1000;

  // ==========================================================
  // Timing: one cycle-period step, in microseconds
  localparam int CYCLE_UNIT_US = 35000;
  localparam int CLK_MHZ = 50;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    PS_ACTIVE = 2'b00,
    PS_STANDBY = 2'b01,
    PS_COMBO = 2'b10,
    PS_DEEP = 2'b11
  } tps_pstate_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_SCAN = 2'b01,
    SQ_WAIT = 2'b10
  } tps_seq_t;

  // Sensing settings: sens [2:0], avg [6:4], sample [9:8], cycle [13:12], gain [17:16]
  typedef struct packed {
    logic [13:0] rsvd;
    logic [1:0] gain;
    logic [1:0] rsvd2;
    logic [1:0] cycle;
    logic [1:0] rsvd3;
    logic [1:0] sample;
    logic rsvd4;
    logic [2:0] avg;
    logic rsvd5;
    logic [2:0] sens;
  } tps_cfg_t;

  // One measurement request to the front end
  typedef struct packed {
    logic [2:0] chan;
    logic cal;
    logic [2:0] sens;
    logic [2:0] avg;
    logic [1:0] sample;
    logic [1:0] gain;
  } tps_meas_t;

endpackage

// *** sim/tps_touch_ctrl_asserts.sv ***
// Checker for the touch power-state control block, on its ports only.
// Assumes it is bound onto the top module; one clock domain.
`timescale 1ns/100ps
module tps_touch_ctrl_asserts #(
  parameter int NUM_CH = 8,
  parameter int CYCLE_UNIT_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_wake,
  input wire logic core_awake,
  input wire tps_pkg::tps_pstate_t power_state,
  input wire logic meas_start,
  input wire tps_pkg::tps_meas_t meas_req,
  input wire logic meas_done
);
  // ==========================================================
  // Port relations
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  AST_READY: assert property (pready == (psel && penable))
    else $error("pready not in first access cycle");
  AST_ERR_QUAL: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  AST_START_PULSE: assert property (meas_start |=> !meas_start)
    else $error("meas_start longer than one cycle");
  AST_DONE_GAP: assert property (meas_done |=> !meas_start)
    else $error("meas_start right after meas_done");
  AST_REQ_HOLD: assert property (!meas_start |-> $stable(meas_req))
    else $error("meas_req moved without a request");
  AST_DEEP_IDLE: assert property ((power_state == tps_pkg::PS_DEEP)[*3] |-> !meas_start)
    else $error("scan request in deep sleep");
  AST_WAKE: assert property (core_awake == (power_state != tps_pkg::PS_DEEP || bus_wake))
    else $error("core_awake wrong for state and wake");
  AST_STATE_HOLD: assert property (!(psel && penable && pwrite) |=> $stable(power_state))
    else $error("power state changed without a write");

  // Main scenarios reached
  CV_CAL: cover property (meas_start && meas_req.cal);
  CV_WAKE: cover property (power_state == tps_pkg::PS_DEEP && core_awake);
  CV_COMBO: cover property (power_state == tps_pkg::PS_COMBO && meas_start);
  CV_ERR: cover property (pslverr);
endmodule

// *** sim/tps_afe_model.sv ***
// Model of the analog front end that answers scan requests.
// Assumes the block's meas_start and meas_req ports; one clock.
`timescale 1ns/100ps
module tps_afe_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic meas_start,
  input wire tps_pkg::tps_meas_t meas_req,
  input wire logic [63:0] deltas,
  input wire logic [3:0] lat,
  output logic meas_done,
  output logic [7:0] meas_delta
);
  // ==========================================================
  // Answer each request lat+1 cycles after meas_start is taken
  logic [3:0] cnt_q;
  logic busy_q;

  // Calibration result reads zero; idle data toggles
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      meas_done <= 1'b0;
      meas_delta <= 8'h00;
    end else begin
      meas_done <= 1'b0;
      meas_delta <= ~meas_delta;
      if (meas_start) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        meas_done <= 1'b1;
        meas_delta <= meas_req.cal ? 8'h00 : deltas[meas_req.chan*8 +: 8];
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// *** sim/tps_touch_ctrl_tb.sv ***
// Self-checking bench for the touch power-state control block.
// Assumes the front-end model and the bound checker.
`timescale 1ns/100ps
module tps_touch_ctrl_tb;
  typedef struct packed {
    logic w;
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] ex;
    logic er;
  } tps_row_t;
  // ==========================================================
  // Register rows: optional write, then read with expectation
  tps_row_t rows [18] = '{
    '{0, 0, 0, 12'h014, 32'hFF, 0}, '{0, 0, 0, 12'h018, 0, 0}, '{0, 0, 0, 12'h040, 32'h40, 0},
    '{0, 0, 0, 12'h024, 32'h40, 0}, '{0, 0, 0, 12'h01C, 32'h1000, 0}, '{0, 0, 0, 12'h010, 0, 0},
    '{0, 0, 0, 12'h028, 0, 0}, '{0, 0, 0, 12'hFFC, 0, 1}, '{1, 0, 32'hFFFF_FFF8, 0, 0, 0},
    '{1, 0, 0, 12'h004, 32'h4, 0}, '{1, 0, 32'h1, 12'h004, 32'h5, 0},
    '{1, 0, 32'h2, 12'h004, 32'h6, 0}, '{1, 0, 32'h3, 12'h004, 32'h6, 0},
    '{1, 0, 32'h4, 12'h004, 32'h3, 0}, '{1, 0, 32'h5, 12'h004, 32'h3, 0},
    '{1, 0, 32'h6, 12'h004, 32'h3, 0}, '{1, 0, 32'h7, 12'h004, 32'h3, 0},
    '{1, 0, 0, 12'h004, 32'h4, 0}};
  logic clk_sys, reset, psel, penable, pwrite, bus_wake, pready, pslverr, meas_start;
  logic meas_done, irq, core_awake, er, mon_on, has_last;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] meas_delta, exp_act, exp_stb, seen, fcal, scan;
  logic [63:0] deltas;
  logic [3:0] lat;
  logic [2:0] last, c;
  tps_pkg::tps_pstate_t power_state, exp_st;
  tps_pkg::tps_meas_t meas_req;
  int n_mismatch = 0, compares = 0, n_start = 0, cyc = 0, k;

  tps_touch_ctrl #(.NUM_CH(8), .CYCLE_UNIT_CYC(20)) uut (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_wake(bus_wake),
    .core_awake(core_awake), .power_state(power_state), .meas_start(meas_start),
    .meas_req(meas_req), .meas_done(meas_done), .meas_delta(meas_delta), .irq(irq));
  tps_afe_model afe (.clk_sys(clk_sys), .reset(reset), .meas_start(meas_start),
    .meas_req(meas_req), .deltas(deltas), .lat(lat), .meas_done(meas_done),
    .meas_delta(meas_delta));

  // Clock and timeout
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  task automatic mon(input tps_pkg::tps_pstate_t s, input int n);
    exp_st = s;
    seen = 8'h00;
    repeat (20) @(posedge clk_sys);
    has_last = 1'b0;
    mon_on = 1'b1;
    repeat (n) @(posedge clk_sys);
    mon_on = 1'b0;
  endtask
  function automatic logic [2:0] nxt(input logic [7:0] m, input logic [2:0] l);
    logic [2:0] j;
    j = l;
    for (int i = 0; i < 8; i++) begin
      j = j + 3'h1;
      if (m[j]) return j;
    end
    return l;
  endfunction

  // Request monitor: scan set, order and settings per channel
  assign scan = exp_st == tps_pkg::PS_ACTIVE ? exp_act :
    exp_st == tps_pkg::PS_STANDBY ? exp_stb : exp_act | exp_stb;
  always @(negedge clk_sys) if (meas_start === 1'b1) begin
    n_start++;
    c = meas_req.chan;
    if (!seen[c]) fcal[c] = meas_req.cal;
    seen[c] = 1'b1;
    if (mon_on) begin
      cmp(32'(scan[c]), 32'h1);
      if (has_last) cmp(32'(c), 32'(nxt(scan, last)));
      if (exp_act[c] && exp_st != tps_pkg::PS_STANDBY)
        cmp(32'({meas_req.sens, meas_req.gain}), 32'hD);
      else cmp(32'({meas_req.sens, meas_req.gain}), 32'h16);
      last = c;
      has_last = 1'b1;
    end
  end

  initial begin
    {reset, psel, penable, pwrite, bus_wake, mon_on, has_last} = 7'h40;
    {paddr, pwdata, deltas, lat, last, seen, fcal} = '0;
    {exp_act, exp_stb, exp_st} = {8'hFF, 8'h00, tps_pkg::PS_ACTIVE};
    lat = 4'h1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].wa, rows[i].wd);
      chk(rows[i].ra, rows[i].ex);
      cmp(32'(er), 32'(rows[i].er));
    end
    $display("test registers done");
    wr(12'h01C, 32'h0001_1003);
    wr(12'h020, 32'h0002_0025);
    wr(12'h048, 32'h60);
    wr(12'h028, 32'h3);
    wr(12'h010, 32'h1FF);
    wr(12'h018, 32'h11);
    wr(12'h014, 32'h7);
    {exp_act, exp_stb} = 16'h0711;
    deltas <= 64'h50_5050;
    mon(tps_pkg::PS_ACTIVE, 300);
    chk(12'h008, 32'h3);
    chk(12'h00C, 32'h103);
    cmp(32'(irq), 32'h1);
    wr(12'h010, 32'h0);
    @(negedge clk_sys);
    cmp(32'(irq), 32'h0);
    wr(12'h00C, 32'h103);
    wr(12'h010, 32'h1FF);
    chk(12'h00C, 32'h0);
    cmp(32'(irq), 32'h0);
    $display("test active done");
    wr(12'h000, 32'h1);
    chk(12'h008, 32'h1);
    mon(tps_pkg::PS_STANDBY, 200);
    lat <= 4'h6;
    wr(12'h000, 32'h2);
    mon(tps_pkg::PS_COMBO, 300);
    cmp(32'(fcal[2:1]), 32'h3);
    $display("test standby and combo done");
    wr(12'h000, 32'h4);
    repeat (10) @(posedge clk_sys);
    k = n_start;
    bus_wake <= 1'b1;
    repeat (200) @(posedge clk_sys);
    cmp(n_start, k);
    cmp(32'(core_awake), 32'h1);
    cmp(32'(power_state), 32'(tps_pkg::PS_DEEP));
    bus_wake <= 1'b0;
    @(negedge clk_sys);
    cmp(32'(core_awake), 32'h0);
    wr(12'h000, 32'h0);
    repeat (100) @(posedge clk_sys);
    cmp(32'(n_start > k), 32'h1);
    $display("test deep sleep done");
    wr(12'h000, 32'h2);
    reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp(32'(power_state), 32'(tps_pkg::PS_ACTIVE));
    cmp(32'(irq), 32'h0);
    reset <= 1'b0;
    chk(12'h014, 32'hFF);
    $display("test reset done");
    summarize();
  end
endmodule

bind tps_touch_ctrl tps_touch_ctrl_asserts #(.NUM_CH(NUM_CH), .CYCLE_UNIT_CYC(CYCLE_UNIT_CYC))
  u_ast (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .bus_wake(bus_wake), .core_awake(core_awake),
  .power_state(power_state), .meas_start(meas_start), .meas_req(meas_req),
  .meas_done(meas_done));
